// ==== rtl/regulator_consts.svh ====
// offsets, field positions, reset values and counts of the regulator control block
`ifndef REGULATOR_CONSTS_SVH
`define REGULATOR_CONSTS_SVH
`define CTRL_ADDR 8'hc9
`define CTRL_PAGE 8'h00
`define EVT_STAT_ADDR 8'hca
`define EVT_MASK_ADDR 8'hcb
`define IRQ_EN_ADDR 8'he6
`define IRQ_PRI_ADDR 8'hf6
`define CTRL_DIS_BIT 7
`define CTRL_RSV_BIT 6
`define CTRL_MODE_BIT 4
`define CTRL_FLAG_BIT 0
`define CTRL_RESET 8'h50
`define IRQ_BIT 0
`define IRQ_EN_RESET 1'b0
`define IRQ_PRI_RESET 1'b0
`define EVT_ENTER_BIT 0
`define EVT_LEAVE_BIT 1
`define EVT_COUNT 2
`define EVT_MASK_RESET 2'h0
`endif

// ==== rtl/regulator_pkg.sv ====
// types shared by the regulator control block
package regulator_pkg;
    typedef logic [7:0] byte_t;
    typedef enum {SEL_NONE, SEL_CTRL, SEL_EVT_STAT, SEL_EVT_MASK, SEL_IRQ_EN,
        SEL_IRQ_PRI} reg_sel_e;
    typedef enum {HEAD_OK, HEAD_LOST} headroom_state_e;
endpackage : regulator_pkg

// ==== rtl/event_if.sv ====
// carrier between the register logic and the sticky event status
`timescale 1ns/1ps
`include "regulator_consts.svh"
interface event_if;
    logic [`EVT_COUNT-1:0] set;
    logic [`EVT_COUNT-1:0] wdata;
    logic clr_wr;
    logic mask_wr;
    logic [`EVT_COUNT-1:0] status;
    logic [`EVT_COUNT-1:0] mask;
    logic irq;
    modport owner (input set, input wdata, input clr_wr, input mask_wr,
        output status, output mask, output irq);
    modport user (output set, output wdata, output clr_wr, output mask_wr,
        input status, input mask, input irq);
endinterface : event_if

// ==== rtl/level_sync.sv ====
// two-stage synchroniser for an asynchronous level
`timescale 1ns/1ps
module level_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_ff;
    logic sync_ff;
    logic nxt_meta;
    logic nxt_sync;

    always_comb begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;
endmodule : level_sync

// ==== rtl/event_status.sv ====
// sticky event bits, write-one-to-clear, with mask and one level interrupt
`timescale 1ns/1ps
`include "regulator_consts.svh"
module event_status (
    input wire logic clk,
    input wire logic reset_n,
    event_if.owner ev
);
    logic [`EVT_COUNT-1:0] status_ff;
    logic [`EVT_COUNT-1:0] nxt_status;
    logic [`EVT_COUNT-1:0] mask_ff;
    logic [`EVT_COUNT-1:0] nxt_mask;
    logic irq_ff;
    logic nxt_irq;

    genvar i;
    generate
        for (i = 0; i < `EVT_COUNT; i++) begin : g_bit
            // a set in the clearing cycle wins
            always_comb begin
                nxt_status[i] = ev.set[i] | (status_ff[i] & ~(ev.clr_wr & ev.wdata[i]));
            end
        end
    endgenerate

    always_comb begin
        nxt_mask = ev.mask_wr ? ev.wdata : mask_ff;
        nxt_irq = |(nxt_status & nxt_mask);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_ff <= '0;
            mask_ff <= `EVT_MASK_RESET;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            irq_ff <= nxt_irq;
        end
    end

    assign ev.status = status_ff;
    assign ev.mask = mask_ff;
    assign ev.irq = irq_ff;
endmodule : event_status

// ==== rtl/regulator_control_status.sv ====
// control register, dropout flag and dropout interrupt of the supply regulator
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "regulator_consts.svh"
module regulator_control_status
    import regulator_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_page,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic dropout_async,
    output logic regulator_enable,
    output logic output_level_select,
    output logic dropout_irq,
    output logic dropout_irq_priority,
    output logic event_irq
);
    logic headroom_lost_flag;
    reg_sel_e sel;
    logic wr_ctrl;
    logic wr_irq_en;
    logic wr_irq_pri;

    logic regulator_disable_ff;
    logic nxt_regulator_disable;
    logic output_level_select_ff;
    logic nxt_output_level_select;
    logic regulator_irq_enable_ff;
    logic nxt_regulator_irq_enable;
    logic regulator_irq_priority_ff;
    logic nxt_regulator_irq_priority;
    logic dropout_irq_ff;
    logic nxt_dropout_irq;
    byte_t rdata_ff;
    byte_t nxt_rdata;
    byte_t ctrl_view;
    headroom_state_e state_ff;
    headroom_state_e nxt_state;
    logic enter_pulse;
    logic leave_pulse;
    localparam byte_t ctrl_reset_value = `CTRL_RESET;

    event_if ev ();

    // comparator output into the clock domain
    level_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in(dropout_async),
        .sync_out(headroom_lost_flag)
    );

    event_status u_events (
        .clk(clk),
        .reset_n(reset_n),
        .ev(ev.owner)
    );

    // address decode, page qualified
    always_comb begin
        sel = SEL_NONE;
        if (reg_page == `CTRL_PAGE) begin
            case (reg_addr)
                `CTRL_ADDR: sel = SEL_CTRL;
                `EVT_STAT_ADDR: sel = SEL_EVT_STAT;
                `EVT_MASK_ADDR: sel = SEL_EVT_MASK;
                `IRQ_EN_ADDR: sel = SEL_IRQ_EN;
                `IRQ_PRI_ADDR: sel = SEL_IRQ_PRI;
                default: sel = SEL_NONE;
            endcase
        end
    end

    assign wr_ctrl = reg_wr && (sel == SEL_CTRL);
    assign wr_irq_en = reg_wr && (sel == SEL_IRQ_EN);
    assign wr_irq_pri = reg_wr && (sel == SEL_IRQ_PRI);

    // only the disable and level bits store; the flag has no write path
    always_comb begin
        nxt_regulator_disable = regulator_disable_ff;
        nxt_output_level_select = output_level_select_ff;
        if (wr_ctrl) begin
            nxt_regulator_disable = reg_wdata[`CTRL_DIS_BIT];
            nxt_output_level_select = reg_wdata[`CTRL_MODE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            regulator_disable_ff <= ctrl_reset_value[`CTRL_DIS_BIT];
            output_level_select_ff <= ctrl_reset_value[`CTRL_MODE_BIT];
        end else begin
            regulator_disable_ff <= nxt_regulator_disable;
            output_level_select_ff <= nxt_output_level_select;
        end
    end

    assign regulator_enable = ~regulator_disable_ff;
    assign output_level_select = output_level_select_ff;

    // interrupt enable and priority bits
    always_comb begin
        nxt_regulator_irq_enable = regulator_irq_enable_ff;
        nxt_regulator_irq_priority = regulator_irq_priority_ff;
        if (wr_irq_en) begin
            nxt_regulator_irq_enable = reg_wdata[`IRQ_BIT];
        end
        if (wr_irq_pri) begin
            nxt_regulator_irq_priority = reg_wdata[`IRQ_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            regulator_irq_enable_ff <= `IRQ_EN_RESET;
            regulator_irq_priority_ff <= `IRQ_PRI_RESET;
        end else begin
            regulator_irq_enable_ff <= nxt_regulator_irq_enable;
            regulator_irq_priority_ff <= nxt_regulator_irq_priority;
        end
    end

    assign dropout_irq_priority = regulator_irq_priority_ff;

    // live request, nothing latched: it drops one cycle after the flag does, and on the same edge as the enable does
    always_comb begin
        nxt_dropout_irq = headroom_lost_flag & nxt_regulator_irq_enable;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dropout_irq_ff <= 1'b0;
        end else begin
            dropout_irq_ff <= nxt_dropout_irq;
        end
    end

    assign dropout_irq = dropout_irq_ff;

    // edge tracker of the flag feeding the sticky events
    always_comb begin
        nxt_state = state_ff;
        enter_pulse = 1'b0;
        leave_pulse = 1'b0;
        case (state_ff)
            HEAD_OK: begin
                if (headroom_lost_flag) begin
                    nxt_state = HEAD_LOST;
                    enter_pulse = 1'b1;
                end
            end
            HEAD_LOST: begin
                if (!headroom_lost_flag) begin
                    nxt_state = HEAD_OK;
                    leave_pulse = 1'b1;
                end
            end
            default: nxt_state = HEAD_OK;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_ff <= HEAD_OK;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_comb begin
        ev.set = '0;
        ev.set[`EVT_ENTER_BIT] = enter_pulse;
        ev.set[`EVT_LEAVE_BIT] = leave_pulse;
        ev.wdata = reg_wdata[`EVT_COUNT-1:0];
        ev.clr_wr = reg_wr && (sel == SEL_EVT_STAT);
        ev.mask_wr = reg_wr && (sel == SEL_EVT_MASK);
    end

    assign event_irq = ev.irq;

    // control register as read: reserved reads 1, unused read 0, flag is live
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[`CTRL_DIS_BIT] = regulator_disable_ff;
        ctrl_view[`CTRL_RSV_BIT] = 1'b1;
        ctrl_view[`CTRL_MODE_BIT] = output_level_select_ff;
        ctrl_view[`CTRL_FLAG_BIT] = headroom_lost_flag;
    end

    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            case (sel)
                SEL_CTRL: nxt_rdata = ctrl_view;
                SEL_EVT_STAT: nxt_rdata = {6'h00, ev.status};
                SEL_EVT_MASK: nxt_rdata = {6'h00, ev.mask};
                SEL_IRQ_EN: nxt_rdata = {7'h00, regulator_irq_enable_ff};
                SEL_IRQ_PRI: nxt_rdata = {7'h00, regulator_irq_priority_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_ctrl_read;
        reg_rd && reg_page == 8'h00 && reg_addr == 8'hc9;
    endsequence

    sequence s_ctrl_write;
        reg_wr && reg_page == 8'h00 && reg_addr == 8'hc9;
    endsequence

    property p_disable_bit;
        s_ctrl_write ##0 reg_wdata[7] |=> !regulator_enable;
    endproperty
    a_disable_bit: assert property (p_disable_bit)
        else $error("regulator still on after disable write");

    property p_enable_bit;
        s_ctrl_write ##0 !reg_wdata[7] |=> regulator_enable;
    endproperty
    a_enable_bit: assert property (p_enable_bit)
        else $error("regulator still off after enable write");

    property p_reset_enabled;
        disable iff (1'b0) !reset_n |=> regulator_enable;
    endproperty
    a_reset_enabled: assert property (p_reset_enabled)
        else $error("regulator not enabled after reset");

    property p_level_select;
        s_ctrl_write |=> output_level_select == $past(reg_wdata[4]);
    endproperty
    a_level_select: assert property (p_level_select)
        else $error("output level does not follow written bit");

    property p_level_hold;
        !(reg_wr && reg_addr == 8'hc9) ##1 !(reg_wr && reg_addr == 8'hc9)
            |-> $stable(output_level_select);
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("output level changed without a write");

    property p_flag_read;
        s_ctrl_read |=> reg_rdata[0] == $past(headroom_lost_flag);
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("dropout flag read back wrong");

    property p_flag_no_sw_clear;
        s_ctrl_write ##0 headroom_lost_flag ##1 s_ctrl_read ##0 headroom_lost_flag
            |=> reg_rdata[0];
    endproperty
    a_flag_no_sw_clear: assert property (p_flag_no_sw_clear)
        else $error("dropout flag cleared by a write");

    property p_irq_raise;
        headroom_lost_flag && regulator_irq_enable_ff && !wr_irq_en |=> dropout_irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("dropout interrupt missing");

    property p_irq_gated;
        dropout_irq |-> $past(headroom_lost_flag) && regulator_irq_enable_ff;
    endproperty
    a_irq_gated: assert property (p_irq_gated)
        else $error("dropout interrupt without cause");

    property p_irq_not_held;
        $fell(headroom_lost_flag) |=> !dropout_irq;
    endproperty
    a_irq_not_held: assert property (p_irq_not_held)
        else $error("dropout interrupt held after flag cleared");

    property p_priority;
        reg_wr && reg_page == 8'h00 && reg_addr == 8'hf6
            |=> dropout_irq_priority == $past(reg_wdata[0]);
    endproperty
    a_priority: assert property (p_priority)
        else $error("priority bit not taken");

    property p_reserved_one;
        s_ctrl_read |=> reg_rdata[6];
    endproperty
    a_reserved_one: assert property (p_reserved_one)
        else $error("reserved bit does not read one");

    property p_unused_zero;
        s_ctrl_read |=> reg_rdata[5] == 1'b0 && reg_rdata[3:1] == 3'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bits not zero");

    property p_ctrl_readback;
        s_ctrl_write ##1 s_ctrl_read
            |=> reg_rdata[7] == $past(reg_wdata[7], 2) && reg_rdata[4] == $past(reg_wdata[4], 2);
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("control register read back wrong");

    property p_wrong_page;
        reg_rd && reg_page != 8'h00 |=> reg_rdata == 8'h00;
    endproperty
    a_wrong_page: assert property (p_wrong_page)
        else $error("register answered on a wrong page");

    property p_sync_delay;
        $rose(headroom_lost_flag) |-> $past(dropout_async, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("flag rose without two-stage delay");

    property p_event_enter;
        $rose(headroom_lost_flag) |=> ev.status[0];
    endproperty
    a_event_enter: assert property (p_event_enter)
        else $error("dropout entry event not recorded");
endmodule : regulator_control_status

// ==== test/regulator_control_status_tb.sv ====
// self-checking bench of the regulator control block with a behavioural register model
`timescale 1ns/1ps
`include "regulator_consts.svh"
module regulator_control_status_tb
    import regulator_pkg::*;
;
    logic clk;
    logic reset_n;
    byte_t reg_addr;
    byte_t reg_page;
    byte_t reg_wdata;
    logic reg_wr;
    logic reg_rd;
    byte_t reg_rdata;
    logic dropout_async;
    logic regulator_enable;
    logic output_level_select;
    logic dropout_irq;
    logic dropout_irq_priority;
    logic event_irq;
    int err_total;
    int compares;
    logic [31:0] rng_state;
    // model state, written from the rules only
    int m_dis;
    int m_lvl;
    int m_ien;
    int m_pri;
    int m_mask;
    int m_stat;
    int m_flag;
    byte_t v;
    byte_t w;
    byte_t unmapped[4] = '{8'hc8, 8'hcc, 8'he7, 8'h00};

    regulator_control_status i_dut (
        .clk(clk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_page(reg_page),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .dropout_async(dropout_async),
        .regulator_enable(regulator_enable),
        .output_level_select(output_level_select),
        .dropout_irq(dropout_irq),
        .dropout_irq_priority(dropout_irq_priority),
        .event_irq(event_irq)
    );

    always #20 clk = ~clk;

    function logic [31:0] xs_next();
        rng_state ^= rng_state << 13;
        rng_state ^= rng_state >> 17;
        rng_state ^= rng_state << 5;
        return rng_state;
    endfunction : xs_next

    task automatic model_reset();
        m_dis = 0;
        m_lvl = 1;
        m_ien = 0;
        m_pri = 0;
        m_mask = 0;
        m_stat = 0;
        m_flag = 0;
    endtask : model_reset

    function automatic byte_t exp_of(input byte_t a, input byte_t pg);
        if (pg !== 8'h00) return 8'h00;
        case (a)
            `CTRL_ADDR: return {m_dis[0], 1'b1, 1'b0, m_lvl[0], 3'b000, m_flag[0]};
            `EVT_STAT_ADDR: return 8'(m_stat);
            `EVT_MASK_ADDR: return 8'(m_mask);
            `IRQ_EN_ADDR: return 8'(m_ien);
            `IRQ_PRI_ADDR: return 8'(m_pri);
            default: return 8'h00;
        endcase
    endfunction : exp_of

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic outs();
        chk("regulator_enable", {7'h0, !m_dis[0]}, {7'h0, regulator_enable});
        chk("output_level_select", {7'h0, m_lvl[0]}, {7'h0, output_level_select});
        chk("dropout_irq", {7'h0, m_ien[0] & m_flag[0]}, {7'h0, dropout_irq});
        chk("priority", {7'h0, m_pri[0]}, {7'h0, dropout_irq_priority});
        chk("event_irq", {7'h0, |(m_stat & m_mask)}, {7'h0, event_irq});
    endtask : outs

    task automatic wr(input byte_t a, input byte_t d, input byte_t pg);
        @(posedge clk);
        reg_addr <= a;
        reg_page <= pg;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input byte_t a, input byte_t pg, output byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_page <= pg;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic wreg(input byte_t a, input byte_t d, input byte_t pg);
        wr(a, d, pg);
        model_wr(a, d, pg);
        outs();
    endtask : wreg

    task automatic model_wr(input byte_t a, input byte_t d, input byte_t pg);
        if (pg === 8'h00) begin
            case (a)
                `CTRL_ADDR: begin
                    m_dis = d[7];
                    m_lvl = d[4];
                end
                `EVT_STAT_ADDR: m_stat = m_stat & ~int'(d[1:0]);
                `EVT_MASK_ADDR: m_mask = d[1:0];
                `IRQ_EN_ADDR: m_ien = d[0];
                `IRQ_PRI_ADDR: m_pri = d[0];
                default: ;
            endcase
        end
    endtask : model_wr

    task automatic rreg(input byte_t a, input byte_t pg);
        rd(a, pg, v);
        chk("read data", exp_of(a, pg), v);
    endtask : rreg

    // write, then read in the very next cycle with the strobes back to back
    task automatic wr_rd(input byte_t a, input byte_t d, input byte_t pg);
        @(posedge clk);
        reg_addr <= a;
        reg_page <= pg;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        model_wr(a, d, pg);
        chk("read data", exp_of(a, pg), reg_rdata);
        outs();
    endtask : wr_rd

    task automatic set_drop(input logic lvl);
        @(posedge clk);
        dropout_async <= lvl;
        repeat (5) @(posedge clk);
        #1;
        if (lvl && !m_flag[0]) m_stat = m_stat | 1;
        if (!lvl && m_flag[0]) m_stat = m_stat | 2;
        m_flag = lvl;
        outs();
    endtask : set_drop

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        end_of_test();
    end

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_page = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        dropout_async = 1'b0;
        err_total = 0;
        compares = 0;
        rng_state = 32'h30;
        model_reset();
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        outs();
        rreg(`CTRL_ADDR, `CTRL_PAGE);
        rreg(`EVT_STAT_ADDR, 8'h00);
        rreg(`EVT_MASK_ADDR, 8'h00);
        rreg(`IRQ_EN_ADDR, 8'h00);
        rreg(`IRQ_PRI_ADDR, 8'h00);
        // fixed corner values first, then random control bytes with bit 6 kept at 1
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 8'hff : (i == 1) ? 8'h40 : 8'(xs_next() | 32'h40);
            wreg(`CTRL_ADDR, w, `CTRL_PAGE);
            rreg(`CTRL_ADDR, `CTRL_PAGE);
            wr_rd(`CTRL_ADDR, w ^ 8'h90, `CTRL_PAGE);
        end
        // unmapped addresses and a wrong page neither store nor answer
        foreach (unmapped[i]) begin
            wreg(unmapped[i], 8'hff, 8'h00);
            rreg(unmapped[i], 8'h00);
        end
        wreg(`CTRL_ADDR, 8'hc0, 8'h01);
        rreg(`CTRL_ADDR, 8'h01);
        rreg(`CTRL_ADDR, `CTRL_PAGE);
        // dropout flag follows the comparator, software cannot clear it
        set_drop(1'b1);
        rreg(`CTRL_ADDR, `CTRL_PAGE);
        wreg(`CTRL_ADDR, 8'h50, `CTRL_PAGE);
        rreg(`CTRL_ADDR, `CTRL_PAGE);
        wr_rd(`CTRL_ADDR, 8'h51, `CTRL_PAGE);
        set_drop(1'b0);
        rreg(`CTRL_ADDR, `CTRL_PAGE);
        // interrupt gated by enable, no pending latch
        wreg(`IRQ_EN_ADDR, 8'h01, 8'h00);
        set_drop(1'b1);
        wreg(`IRQ_EN_ADDR, 8'h00, 8'h00);
        set_drop(1'b0);
        rreg(`CTRL_ADDR, `CTRL_PAGE);
        wreg(`IRQ_EN_ADDR, 8'h01, 8'h00);
        rreg(`IRQ_EN_ADDR, 8'h00);
        set_drop(1'b1);
        set_drop(1'b0);
        wreg(`IRQ_PRI_ADDR, 8'h01, 8'h00);
        rreg(`IRQ_PRI_ADDR, 8'h00);
        // sticky events, mask and write-one-to-clear
        rreg(`EVT_STAT_ADDR, 8'h00);
        wreg(`EVT_MASK_ADDR, 8'h01, 8'h00);
        wreg(`EVT_STAT_ADDR, 8'h01, 8'h00);
        rreg(`EVT_STAT_ADDR, 8'h00);
        wreg(`EVT_MASK_ADDR, 8'h03, 8'h00);
        rreg(`EVT_MASK_ADDR, 8'h00);
        wreg(`EVT_STAT_ADDR, 8'h03, 8'h00);
        rreg(`EVT_STAT_ADDR, 8'h00);
        set_drop(1'b1);
        wreg(`CTRL_ADDR, 8'hc0, `CTRL_PAGE);
        // second reset in mid-run with dropout active and everything changed
        @(posedge clk);
        reset_n <= 1'b0;
        dropout_async <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        model_reset();
        outs();
        rreg(`CTRL_ADDR, `CTRL_PAGE);
        rreg(`IRQ_EN_ADDR, 8'h00);
        rreg(`EVT_MASK_ADDR, 8'h00);
        end_of_test();
    end
endmodule : regulator_control_status_tb
